/* File: pkg/tbvc_cfg.svh */
`ifndef TBVC_CFG_SVH
`define TBVC_CFG_SVH
// main clock period, ns
`define TBVC_CLK_PERIOD_NS 8
// trigger selection: external trigger enable bit
`define TBVC_EXT_SEL_BIT 4
// circular memory geometry
`define TBVC_CELLS_PER_COL 20
`define TBVC_CHANNELS 4
// fast vernier calibration
`define TBVC_CAL_TRIGGERS 16384
`define TBVC_CAL_WORDS_PER_TRIG 4
// header words ahead of the samples: trigger record, then verniers
`define TBVC_HDR_WORDS 8
// completion flag position and least dead time
`define TBVC_FLAG_BIT 0
`define TBVC_DEAD_MIN 16'h0001
`define TBVC_FIFO_DEPTH 4
`endif

/* File: pkg/tbvc_pkg.sv */
`include "tbvc_cfg.svh"
package tbvc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_REARM, ST_ARMED, ST_POST, ST_XFER, ST_CAL
    } tbvc_state_e_t;

    typedef struct packed {
        tbvc_state_e_t state;
        logic [15:0] deadCnt;
        logic [4:0] cellIdx;
        logic [6:0] colIdx;
        logic colSync;
        logic [15:0] postCnt;
        logic [6:0] trigRec;
        logic trigPrev;
        logic trigRepeat;
        logic [3:0][15:0] vernier;
        logic calMode;
        logic [16:0] calTrigCnt;
        logic [15:0] wordIdx;
        logic [15:0] ramAddr;
        logic completionFlag;
        logic panelOut;
    } tbvc_ctrl_t;
endpackage

/* File: core/tbvc_fifo.sv */
`timescale 1ns/10ps
`include "tbvc_cfg.svh"
module tbvc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = `TBVC_FIFO_DEPTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rdPtr;
        logic [AW-1:0] wrPtr;
        logic [AW:0] count;
    } tbvc_fifo_t;
    tbvc_fifo_t st, next_st;
    logic push, pop;

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
        $error("fifo depth must be a power of two of at least 2");
    end

    assign inReady = (st.count != (AW+1)'(DEPTH));
    assign outValid = (st.count != '0);
    assign outData = st.mem[st.rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wrPtr] = inData;
            next_st.wrPtr = st.wrPtr + 1'b1;
        end
        if (pop) begin
            next_st.rdPtr = st.rdPtr + 1'b1;
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule // tbvc_fifo

/* File: core/tbvc_acq_ctrl.sv */
`timescale 1ns/10ps
`include "tbvc_cfg.svh"
module tbvc_acq_ctrl
    import tbvc_pkg::*;
#(
    parameter int FIFO_DEPTH = `TBVC_FIFO_DEPTH,
    parameter int CAL_TRIGGERS = `TBVC_CAL_TRIGGERS
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // configuration
    input wire logic [7:0] triggerSelect,
    input wire logic autoTrigger,
    input wire logic randomTriggerEn,
    input wire logic [7:0] readoutColumnCount,
    input wire logic [15:0] postTriggerLength,
    input wire logic [15:0] rearmLength,
    input wire logic syncSelectStrap,
    input wire logic busySelectStrap,
    // commands
    input wire logic acquisitionLaunch,
    input wire logic completionClear,
    input wire logic softTrigger,
    // trigger sources and interpolator
    input wire logic externalTriggerIn,
    input wire logic channelTriggerIn,
    input wire logic randomTriggerIn,
    input wire logic [63:0] vernierIn,
    // samples from the sampling chips
    input wire logic [15:0] sampleIn,
    output logic sampleTake,
    // ram write side
    output logic ramWrValid,
    input wire logic ramWrReady,
    output logic [15:0] ramWrData,
    output logic [15:0] ramWrAddr,
    // status and panel
    output logic busy,
    output logic trigger_repeat_out,
    output logic syncBusyOut,
    output logic [7:0] completionReg,
    output logic irq
);
    import tbvc_pkg::*;

    if (FIFO_DEPTH < 2 || CAL_TRIGGERS < 1 ||
        CAL_TRIGGERS > 65536) begin : g_bad
        $error("unsupported fifo depth or calibration trigger count");
    end

    localparam logic [4:0] LAST_CELL = 5'(`TBVC_CELLS_PER_COL - 1);
    localparam logic [16:0] CAL_LAST = 17'(CAL_TRIGGERS - 1);
    localparam logic [15:0] HDR = 16'(`TBVC_HDR_WORDS);
    localparam logic [15:0] CAL_W = 16'(`TBVC_CAL_WORDS_PER_TRIG);

    tbvc_ctrl_t st, next_st;
    logic trigRaw, trigRise, trigAccept, recording;
    logic pushValid, pushReady, push, wordLast;
    logic [15:0] pushData, xferWords, deadLoad;
    logic fifoValid;
    logic [15:0] fifoData;

    // auto mode uses software or random triggers, else the async source
    always_comb begin
        if (autoTrigger) begin
            trigRaw = softTrigger || (randomTriggerEn && randomTriggerIn);
        end else if (triggerSelect[`TBVC_EXT_SEL_BIT]) begin
            trigRaw = externalTriggerIn;
        end else begin
            trigRaw = channelTriggerIn;
        end
    end

    assign trigRise = trigRaw && !st.trigPrev;
    // a single accept strobe serves all channels
    assign trigAccept = trigRise && (st.state == ST_ARMED);
    assign recording = (st.state == ST_REARM) || (st.state == ST_ARMED) ||
        (st.state == ST_POST);
    // zero would mean no dead time at all, which the chips cannot stand
    assign deadLoad = (rearmLength == '0) ? `TBVC_DEAD_MIN : rearmLength;
    assign xferWords = HDR + 16'(readoutColumnCount) * 16'(`TBVC_CELLS_PER_COL)
        * 16'(`TBVC_CHANNELS);

    // word sequencer feeding the fifo
    always_comb begin
        pushValid = 1'b0;
        pushData = '0;
        wordLast = 1'b0;
        sampleTake = 1'b0;
        if (st.state == ST_CAL) begin
            pushValid = 1'b1;
            pushData = st.vernier[2'd3 - st.wordIdx[1:0]];
            wordLast = (st.wordIdx == CAL_W - 16'd1);
        end else if (st.state == ST_XFER) begin
            pushValid = 1'b1;
            wordLast = (st.wordIdx == xferWords - 16'd1);
            if (st.wordIdx < 16'(`TBVC_CHANNELS)) begin
                pushData = {9'h000, st.trigRec};
            end else if (st.wordIdx < HDR) begin
                // verniers follow the trigger record words
                pushData = st.vernier[st.wordIdx[1:0]];
            end else begin
                pushData = sampleIn;
                // valid is set on this path, so readiness alone decides
                sampleTake = pushReady;
            end
        end
    end

    assign push = pushValid && pushReady;

    always_comb begin
        next_st = st;
        next_st.trigPrev = trigRaw;
        next_st.trigRepeat = trigAccept;
        next_st.colSync = 1'b0;
        if (recording) begin
            if (st.cellIdx == LAST_CELL) begin
                next_st.cellIdx = '0;
                next_st.colIdx = st.colIdx + 7'h01;
                next_st.colSync = (st.colIdx == 7'h00);
            end else begin
                next_st.cellIdx = st.cellIdx + 5'h01;
            end
        end
        if (ramWrValid && ramWrReady) begin
            // linear addresses let the host burst-read the ram
            next_st.ramAddr = st.ramAddr + 16'h0001;
        end
        unique case (st.state)
            ST_IDLE: begin
            end
            ST_REARM: begin
                if (st.deadCnt <= 16'h0001) begin
                    next_st.state = ST_ARMED;
                end else begin
                    next_st.deadCnt = st.deadCnt - 16'h0001;
                end
            end
            ST_ARMED: begin
                if (trigAccept) begin
                    next_st.vernier = vernierIn;
                    next_st.trigRec = st.colIdx;
                    next_st.wordIdx = '0;
                    next_st.postCnt = postTriggerLength;
                    next_st.state = st.calMode ? ST_CAL : ST_POST;
                end
            end
            ST_POST: begin
                if (st.postCnt == '0) begin
                    next_st.state = ST_XFER;
                end else if (st.cellIdx == LAST_CELL) begin
                    next_st.postCnt = st.postCnt - 16'h0001;
                end
            end
            ST_XFER: begin
                if (push) begin
                    next_st.wordIdx = st.wordIdx + 16'h0001;
                    if (wordLast) begin
                        next_st.completionFlag = 1'b1;
                        next_st.state = ST_IDLE;
                    end
                end
            end
            ST_CAL: begin
                if (push) begin
                    next_st.wordIdx = st.wordIdx + 16'h0001;
                    if (wordLast) begin
                        next_st.calTrigCnt = st.calTrigCnt + 17'h00001;
                        next_st.deadCnt = deadLoad;
                        next_st.state = ST_REARM;
                        if (st.calTrigCnt == CAL_LAST) begin
                            next_st.completionFlag = 1'b1;
                            next_st.state = ST_IDLE;
                        end
                    end
                end
            end
        endcase
        // host acknowledge loses against a flag set in the same cycle
        if (completionClear &&
            !(next_st.completionFlag && !st.completionFlag)) begin
            next_st.completionFlag = 1'b0;
        end
        if (acquisitionLaunch) begin
            next_st.completionFlag = 1'b0;
            next_st.calMode = (readoutColumnCount == 8'h00) &&
                autoTrigger && randomTriggerEn;
            next_st.calTrigCnt = '0;
            next_st.ramAddr = '0;
            next_st.deadCnt = deadLoad;
            next_st.state = ST_REARM;
        end
        // strap picks busy or column sync for the shared panel output
        if (busySelectStrap) begin
            next_st.panelOut = (next_st.state != ST_ARMED);
        end else if (syncSelectStrap) begin
            next_st.panelOut = next_st.colSync;
        end else begin
            next_st.panelOut = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    tbvc_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) tbvc_fifo_i (
        .mclk(mclk),
        .rst_n(rst_n),
        .inValid(pushValid),
        .inReady(pushReady),
        .inData(pushData),
        .outValid(fifoValid),
        .outReady(ramWrReady),
        .outData(fifoData)
    );

    assign ramWrValid = fifoValid;
    assign ramWrData = fifoData;
    assign ramWrAddr = st.ramAddr;
    assign busy = (st.state != ST_ARMED);
    assign trigger_repeat_out = st.trigRepeat;
    assign syncBusyOut = st.panelOut;
    assign completionReg = {7'h00, st.completionFlag};
    assign irq = st.completionFlag;

    a_busy_ignore: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (busy && trigRise) |=> !trigger_repeat_out)
        else $error("trigger taken while busy");
    a_repeat_follows: assert property (
        @(posedge mclk) disable iff (!rst_n)
        trigAccept |=> trigger_repeat_out ##1 !trigger_repeat_out)
        else $error("trigger repeat not a one-cycle echo");
    a_ext_only: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (!autoTrigger && triggerSelect[4] && !externalTriggerIn) |->
        !trigAccept)
        else $error("non-external trigger taken in external mode");
    a_col_sync: assert property (
        @(posedge mclk) disable iff (!rst_n)
        st.colSync |-> (st.colIdx == 7'h01 && st.cellIdx == 5'h00))
        else $error("column sync off the second column start");
    a_busy_ready: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $fell(busy) |-> ($past(st.state) == ST_REARM &&
        $past(st.deadCnt) <= 16'h0001))
        else $error("busy fell before dead time ended");
    a_cal_order: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (st.state == ST_CAL && push && st.wordIdx == 16'h0000) |->
        (pushData == st.vernier[3]))
        else $error("calibration words not starting with channel 3");
    a_flag_launch: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (acquisitionLaunch && !completionClear) |=> !irq && busy)
        else $error("launch did not clear completion flag");
    a_cal_done: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (st.state == ST_CAL && push && wordLast && st.calTrigCnt == CAL_LAST &&
        !acquisitionLaunch) |=>
        (irq && completionReg[0] && st.state == ST_IDLE))
        else $error("calibration end without interrupt");
    a_dead_hold: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (st.state == ST_REARM && st.deadCnt > 16'h0001 && !acquisitionLaunch)
        |=> busy)
        else $error("trigger window opened inside dead time");
    a_panel_busy: assert property (
        @(posedge mclk) disable iff (!rst_n)
        busySelectStrap |=> (syncBusyOut == busy))
        else $error("busy panel output differs from busy");
    a_vernier_slot: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (st.state == ST_XFER && push && st.wordIdx == 16'h0004) |->
        (pushData == st.vernier[0]))
        else $error("channel 0 vernier out of its slot");
    a_clear_ack: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (completionClear && st.state != ST_XFER && st.state != ST_CAL) |=>
        !irq)
        else $error("host acknowledge did not clear the flag");
endmodule // tbvc_acq_ctrl

/* File: verif/tbvc_ram_model.sv */
`timescale 1ns/10ps
module tbvc_ram_model (
    // clock
    input wire logic mclk,
    // ram write side
    input wire logic ramWrValid,
    output logic ramWrReady,
    input wire logic [15:0] ramWrData,
    input wire logic [15:0] ramWrAddr
);
    logic [15:0] dataQ[$];
    logic [15:0] addrQ[$];
    initial ramWrReady = 1'b0;
    // random stalls let words pile up in the fifo until it refuses
    always @(posedge mclk) begin
        if (ramWrValid === 1'b1 && ramWrReady === 1'b1) begin
            dataQ.push_back(ramWrData);
            addrQ.push_back(ramWrAddr);
        end
        #1 ramWrReady <= ($urandom % 4) != 0;
    end
endmodule // tbvc_ram_model

/* File: verif/trigger_busy_vernier_calibration_bench.sv */
`timescale 1ns/10ps
module trigger_busy_vernier_calibration_bench;
    import tbvc_pkg::*;
    localparam int CALN = 4;
    logic mclk, rst_n, autoTrigger, randomTriggerEn, syncSelectStrap;
    logic busySelectStrap, acquisitionLaunch, completionClear;
    logic softTrigger, externalTriggerIn, channelTriggerIn;
    logic randomTriggerIn, sampleTake, ramWrValid, ramWrReady, busy;
    logic trigger_repeat_out, syncBusyOut, irq;
    logic [7:0] triggerSelect, readoutColumnCount, completionReg;
    logic [15:0] postTriggerLength, rearmLength, sampleIn;
    logic [15:0] ramWrData, ramWrAddr;
    logic [63:0] vernierIn;
    int errors, tests_run, repeats, syncs, n, r;
    int deads[6];
    logic [15:0] expQ[$];
    logic [15:0] smpQ[$];

    tbvc_acq_ctrl #(.FIFO_DEPTH(4), .CAL_TRIGGERS(CALN)) tbvc_acq_ctrl_i (
        .mclk, .rst_n, .triggerSelect, .autoTrigger, .randomTriggerEn,
        .readoutColumnCount, .postTriggerLength, .rearmLength,
        .syncSelectStrap, .busySelectStrap, .acquisitionLaunch,
        .completionClear, .softTrigger, .externalTriggerIn,
        .channelTriggerIn, .randomTriggerIn, .vernierIn, .sampleIn,
        .sampleTake, .ramWrValid, .ramWrReady, .ramWrData, .ramWrAddr,
        .busy, .trigger_repeat_out, .syncBusyOut, .completionReg, .irq);
    tbvc_ram_model tbvc_ram_model_i (.mclk, .ramWrValid, .ramWrReady,
        .ramWrData, .ramWrAddr);

    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        if (trigger_repeat_out === 1'b1) repeats++;
        if (syncBusyOut === 1'b1) syncs++;
        if (sampleTake === 1'b1) smpQ.push_back(sampleIn);
        #1 sampleIn <= 16'($urandom);
    end

    task close_out();
        if (errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask

    task launch(input logic [15:0] d);
        rearmLength = d;
        tbvc_ram_model_i.dataQ.delete();
        tbvc_ram_model_i.addrQ.delete();
        expQ.delete();
        smpQ.delete();
        acquisitionLaunch = 1'b1;
        tick(1);
        acquisitionLaunch = 1'b0;
    endtask

    // counts cycles until busy falls, bounded
    task arm();
        n = 0;
        while (busy !== 1'b0 && n < 70000) begin
            tick(1);
            n++;
        end
    endtask

    task drain(input int w, input int from);
        int k;
        k = 0;
        while (tbvc_ram_model_i.dataQ.size() < w && k < 5000) begin
            tick(1);
            k++;
        end
        chk("words", 16'(w), 16'(tbvc_ram_model_i.dataQ.size()));
        for (int i = 0; i < w && i < tbvc_ram_model_i.dataQ.size(); i++) begin
            chk("addr", 16'(i), tbvc_ram_model_i.addrQ[i]);
            if (i >= from)
                chk("data", expQ[i], tbvc_ram_model_i.dataQ[i]);
        end
    endtask

    task wait_irq();
        n = 0;
        while (irq !== 1'b1 && n < 5000) begin
            tick(1);
            n++;
        end
        chk("irq", 16'h0001, 16'(irq));
        chk("completionReg", 16'h0001, 16'(completionReg));
    endtask

    initial begin
        void'($urandom(32'hB76108BB));
        {mclk, autoTrigger, randomTriggerEn, syncSelectStrap} = '0;
        {busySelectStrap, acquisitionLaunch, completionClear} = '0;
        {softTrigger, externalTriggerIn, channelTriggerIn} = '0;
        {randomTriggerIn, triggerSelect, readoutColumnCount} = '0;
        {errors, tests_run, repeats, syncs} = '0;
        postTriggerLength = 16'h0001;
        rearmLength = 16'h0004;
        sampleIn = 16'h0000;
        vernierIn = '0;
        rst_n = 1'b0;
        tick(3);
        chk("busy", 16'h0001, 16'(busy));
        chk("irq", 16'h0000, 16'(irq));
        chk("completionReg", 16'h0000, 16'(completionReg));
        rst_n = 1'b1;
        deads = '{0, 1, 2, 7, 37, 3};
        deads[5] = $urandom_range(60, 3);
        foreach (deads[i]) begin
            r = deads[i];
            launch(16'(r));
            arm();
            chk("dead", 16'(r == 0 ? 1 : r), 16'(n));
            chk("panel", 16'h0000, 16'(syncBusyOut));
        end
        // external source selected, readout of one column
        triggerSelect = 8'h10;
        readoutColumnCount = 8'h01;
        busySelectStrap = 1'b1;
        launch(16'h0004);
        arm();
        tick(2);
        chk("panel", 16'h0000, 16'(syncBusyOut));
        r = repeats;
        pulse(channelTriggerIn);
        chk("repeats", 16'(r), 16'(repeats));
        vernierIn = {$urandom, $urandom};
        pulse(externalTriggerIn);
        tick(1);
        chk("repeats", 16'(r + 1), 16'(repeats));
        chk("busy", 16'h0001, 16'(busy));
        repeat (4) expQ.push_back(16'h0000);
        for (int c = 0; c < 4; c++) expQ.push_back(vernierIn[c*16 +: 16]);
        // header words must be looked at before the rest reach the ram
        drain(8, 4);
        wait_irq();
        chk("samples", 16'd80, 16'(smpQ.size()));
        for (int c = 0; c < 80 && c < smpQ.size(); c++)
            expQ.push_back(smpQ[c]);
        drain(88, 8);
        chk("panel", 16'h0001, 16'(syncBusyOut));
        launch(16'h0004);
        tick(1);
        chk("completionReg", 16'h0000, 16'(completionReg));
        chk("irq", 16'h0000, 16'(irq));
        // fast vernier fill from random triggers
        triggerSelect = 8'h00;
        readoutColumnCount = 8'h00;
        autoTrigger = 1'b1;
        randomTriggerEn = 1'b1;
        launch(16'h0005);
        r = repeats;
        repeat (CALN) begin
            arm();
            vernierIn = {$urandom, $urandom};
            for (int c = 3; c >= 0; c--) expQ.push_back(vernierIn[c*16 +: 16]);
            pulse(randomTriggerIn);
            // a second edge while the calibration words are still being pushed must be dropped
            pulse(randomTriggerIn);
        end
        wait_irq();
        chk("repeats", 16'(r + CALN), 16'(repeats));
        drain(4 * CALN, 0);
        pulse(completionClear);
        chk("irq", 16'h0000, 16'(irq));
        chk("completionReg", 16'h0000, 16'(completionReg));
        // column sync strap: one pulse per wrap of the circular memory
        autoTrigger = 1'b0;
        busySelectStrap = 1'b0;
        syncSelectStrap = 1'b1;
        launch(16'h0004);
        arm();
        syncs = 0;
        tick(128 * 20);
        chk("syncs", 16'h0001, 16'(syncs));
        // software trigger: refused inside the dead time, then taken
        autoTrigger = 1'b1;
        randomTriggerEn = 1'b0;
        launch(16'h0010);
        r = repeats;
        pulse(softTrigger);
        chk("repeats", 16'(r), 16'(repeats));
        arm();
        pulse(softTrigger);
        tick(1);
        chk("repeats", 16'(r + 1), 16'(repeats));
        wait_irq();
        close_out();
    end

    initial begin
        #(8 * 20000);
        errors++;
        close_out();
    end
endmodule // trigger_busy_vernier_calibration_bench
